// ==== logic/bstap_pkg.sv ====
// bstap_pkg: constants, states and carriers for the boundary-scan test port
// assumes a 4-bit instruction and a 32-bit identification word
package bstap_pkg;

  localparam int IR_WIDTH = 4;
  localparam int ID_WIDTH = 32;

  // instruction codes
  localparam logic [3:0] INS_SAMPLE = 4'h1;
  localparam logic [3:0] INS_IDENT  = 4'h2;
  localparam logic [3:0] INS_HIZ    = 4'h3;
  localparam logic [3:0] INS_BYPASS = 4'hf;

  // fixed capture pattern, low two bits are 01
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // identification field positions
  localparam int ID_VER_MSB  = 31;
  localparam int ID_VER_LSB  = 28;
  localparam int ID_PART_MSB = 27;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_MSB  = 11;
  localparam int ID_MFR_LSB  = 1;
  localparam int ID_MARK_BIT = 0;

  // number of tms-high edges that always reach test-logic-reset
  localparam int RESET_EDGES = 5;

  typedef enum logic [3:0] {
    ST_RESET      = 4'h0,
    ST_IDLE       = 4'h1,
    ST_SEL_DR     = 4'h2,
    ST_CAP_DR     = 4'h3,
    ST_SHIFT_DR   = 4'h4,
    ST_EXIT1_DR   = 4'h5,
    ST_PAUSE_DR   = 4'h6,
    ST_EXIT2_DR   = 4'h7,
    ST_UPDATE_DR  = 4'h8,
    ST_SEL_IR     = 4'h9,
    ST_CAP_IR     = 4'ha,
    ST_SHIFT_IR   = 4'hb,
    ST_EXIT1_IR   = 4'hc,
    ST_PAUSE_IR   = 4'hd,
    ST_EXIT2_IR   = 4'he,
    ST_UPDATE_IR  = 4'hf
  } bstap_state_t;

  // decoded instruction plus the test-active flag from the tap state, crosses to the core clock
  typedef struct packed {
    logic sel_ident;
    logic sel_boundary;
    logic sel_bypass;
    logic outputs_off;
    logic test_active;
  } bstap_mode_t;

endpackage

// ==== logic/bstap_sync.sv ====
// bstap_sync: three-stage synchroniser with agreement filter
// assumes i_async is stable for at least three destination clocks
`timescale 1ns/100ps
module bstap_sync
  import bstap_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input  wire logic             i_clk,    // destination clock
  input  wire logic             i_reset,  // async reset, high
  input  wire logic             i_ce,     // clock enable
  input  wire logic [WIDTH-1:0] i_async,  // foreign-domain level
  output logic      [WIDTH-1:0] o_sync    // filtered level
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  // per bit: change taken only when stages two and three agree
  // both high sets, both low clears, disagreement holds the old level
  assign out_next = (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end
    else if (i_ce)
    begin
      s1_reg  <= i_async;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign o_sync = out_reg;

endmodule // bstap_sync

// ==== logic/bstap_top.sv ====
// bstap_top: boundary-scan test access port of the fifo device
// assumes tck from the tester as its own clock, the fifo core on i_mclk
`timescale 1ns/100ps
module bstap_top
  import bstap_pkg::*;
#(
  parameter int              BSR_LEN  = 8,      // boundary cells
  parameter logic [3:0]      ID_VER   = 4'h3,   // arbitrary value
  parameter logic [15:0]     ID_PART  = 16'h0123, // arbitrary value
  parameter logic [10:0]     ID_MFR   = 11'h055   // arbitrary value
)(
  input  wire logic               i_mclk,      // core clock, 20 mhz
  input  wire logic               i_reset,     // core async reset, high
  input  wire logic               i_ce,        // core clock enable
  input  wire logic               i_tck,       // test clock
  input  wire logic               i_tms,       // test mode select
  input  wire logic               i_tdi,       // test data in
  input  wire logic               i_trst_n,    // test reset, low
  output logic                    o_tdo,       // test data out
  output logic                    o_tdo_oe,    // tdo driven
  input  wire logic [BSR_LEN-1:0] i_pin_in,    // functional pin levels
  input  wire logic [BSR_LEN-1:0] i_core_out,  // core values toward pins
  output logic      [BSR_LEN-1:0] o_bsr_data,  // preload cells, core clock
  output logic                    o_outputs_off, // core outputs disabled
  output logic                    o_test_active, // test logic not in reset
  output logic                    o_tap_reset  // tap in test-logic-reset
);

  bstap_state_t state_reg;
  bstap_state_t state_next;
  logic [IR_WIDTH-1:0] ir_shift_reg;
  logic [IR_WIDTH-1:0] ir_shift_next;
  logic [IR_WIDTH-1:0] ir_reg;
  logic                bypass_reg;
  logic                bypass_next;
  logic [ID_WIDTH-1:0] id_shift_reg;
  logic [ID_WIDTH-1:0] id_shift_next;
  logic [BSR_LEN-1:0]  bsr_shift_reg;
  logic [BSR_LEN-1:0]  bsr_shift_next;
  logic [BSR_LEN-1:0]  bsr_upd_reg;
  logic                tdo_reg;
  logic                tdo_oe_reg;
  logic                s_cap_ir;
  logic                s_shift_ir;
  logic                s_cap_dr;
  logic                s_shift_dr;
  logic                s_upd_dr;
  logic [ID_WIDTH-1:0] id_word;
  bstap_mode_t         mode;
  bstap_mode_t         mode_sync;
  logic                serial_mux;
  logic [BSR_LEN:0]    upd_tog_sync;
  logic                upd_tog_reg;
  logic                upd_seen_reg;
  logic [BSR_LEN-1:0]  bsr_core_reg;

  // next-state function of the standard tap graph
  function automatic bstap_state_t tap_next(input bstap_state_t s, input logic tms);
    unique case (s)
      ST_RESET:     tap_next = tms ? ST_RESET     : ST_IDLE;
      ST_IDLE:      tap_next = tms ? ST_SEL_DR    : ST_IDLE;
      ST_SEL_DR:    tap_next = tms ? ST_SEL_IR    : ST_CAP_DR;
      ST_CAP_DR:    tap_next = tms ? ST_EXIT1_DR  : ST_SHIFT_DR;
      ST_SHIFT_DR:  tap_next = tms ? ST_EXIT1_DR  : ST_SHIFT_DR;
      ST_EXIT1_DR:  tap_next = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:  tap_next = tms ? ST_EXIT2_DR  : ST_PAUSE_DR;
      ST_EXIT2_DR:  tap_next = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR: tap_next = tms ? ST_SEL_DR    : ST_IDLE;
      ST_SEL_IR:    tap_next = tms ? ST_RESET     : ST_CAP_IR;
      ST_CAP_IR:    tap_next = tms ? ST_EXIT1_IR  : ST_SHIFT_IR;
      ST_SHIFT_IR:  tap_next = tms ? ST_EXIT1_IR  : ST_SHIFT_IR;
      ST_EXIT1_IR:  tap_next = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:  tap_next = tms ? ST_EXIT2_IR  : ST_PAUSE_IR;
      ST_EXIT2_IR:  tap_next = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR: tap_next = tms ? ST_SEL_DR    : ST_IDLE;
    endcase
  endfunction

  assign state_next = tap_next(state_reg, i_tms);

  // every tms-high path reaches reset within five edges through the graph above
  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
      state_reg <= ST_RESET;
    else
      state_reg <= state_next;
  end

  assign s_cap_ir   = (state_reg == ST_CAP_IR);
  assign s_shift_ir = (state_reg == ST_SHIFT_IR);
  assign s_cap_dr   = (state_reg == ST_CAP_DR);
  assign s_shift_dr = (state_reg == ST_SHIFT_DR);
  assign s_upd_dr   = (state_reg == ST_UPDATE_DR);

  // instruction decode; unknown codes fall to bypass
  assign mode.sel_ident    = (ir_reg == INS_IDENT);
  assign mode.sel_boundary = (ir_reg == INS_SAMPLE);
  assign mode.sel_bypass   = ~mode.sel_ident & ~mode.sel_boundary;
  assign mode.outputs_off  = (ir_reg == INS_HIZ);
  assign mode.test_active  = (state_reg != ST_RESET);

  assign id_word = {ID_VER, ID_PART, ID_MFR, 1'b1};

  // instruction shift stage, lsb leaves first
  assign ir_shift_next = s_cap_ir   ? IR_CAPTURE :
                         s_shift_ir ? {i_tdi, ir_shift_reg[IR_WIDTH-1:1]} :
                         ir_shift_reg;

  assign bypass_next = (s_cap_dr && mode.sel_bypass) ? 1'b0 :
                       (s_shift_dr && mode.sel_bypass) ? i_tdi : bypass_reg;

  assign id_shift_next = (s_cap_dr && mode.sel_ident) ? id_word :
                         (s_shift_dr && mode.sel_ident) ? {i_tdi, id_shift_reg[ID_WIDTH-1:1]} :
                         id_shift_reg;

  // sample captures the pin levels alone per cell; the core drive term cancels out
  assign bsr_shift_next = (s_cap_dr && mode.sel_boundary) ? (i_pin_in | i_core_out) & i_pin_in :
                          (s_shift_dr && mode.sel_boundary) ? {i_tdi, bsr_shift_reg[BSR_LEN-1:1]} :
                          bsr_shift_reg;

  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
    begin
      ir_shift_reg  <= IR_CAPTURE;
      bypass_reg    <= 1'b0;
      id_shift_reg  <= '0;
      bsr_shift_reg <= '0;
    end
    else
    begin
      ir_shift_reg  <= ir_shift_next;
      bypass_reg    <= bypass_next;
      id_shift_reg  <= id_shift_next;
      bsr_shift_reg <= bsr_shift_next;
    end
  end

  assign serial_mux = s_shift_ir       ? ir_shift_reg[0] :
                      mode.sel_ident    ? id_shift_reg[0] :
                      mode.sel_boundary ? bsr_shift_reg[0] : bypass_reg;

  // falling-edge side: instruction latch, boundary update, tdo
  always_ff @(negedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
    begin
      ir_reg      <= INS_IDENT;
      bsr_upd_reg <= '0;
      upd_tog_reg <= 1'b0;
      tdo_reg     <= 1'b0;
      tdo_oe_reg  <= 1'b0;
    end
    else
    begin
      if (state_reg == ST_RESET)
        ir_reg <= INS_IDENT;
      else if (state_reg == ST_UPDATE_IR)
        ir_reg <= ir_shift_reg;
      if (s_upd_dr && mode.sel_boundary)
      begin
        bsr_upd_reg <= bsr_shift_reg;
        upd_tog_reg <= ~upd_tog_reg;
      end
      tdo_reg    <= serial_mux;
      tdo_oe_reg <= s_shift_ir | s_shift_dr;
    end
  end

  assign o_tdo    = tdo_reg;
  assign o_tdo_oe = tdo_oe_reg;

  // mode bits and update toggle cross into the core domain
  bstap_sync #(.WIDTH(5)) u_mode_sync (
    .i_clk   (i_mclk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_async (mode),
    .o_sync  (mode_sync)
  );

  // preload cells are stable once the toggle lands; a single burst is assumed
  bstap_sync #(.WIDTH(BSR_LEN + 1)) u_upd_sync (
    .i_clk   (i_mclk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_async ({upd_tog_reg, bsr_upd_reg}),
    .o_sync  (upd_tog_sync)
  );

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      upd_seen_reg <= 1'b0;
      bsr_core_reg <= '0;
    end
    else if (i_ce)
    begin
      upd_seen_reg <= upd_tog_sync[BSR_LEN];
      if (upd_seen_reg != upd_tog_sync[BSR_LEN])
        bsr_core_reg <= upd_tog_sync[BSR_LEN-1:0];
    end
  end

  assign o_bsr_data    = bsr_core_reg;
  assign o_outputs_off = mode_sync.outputs_off;
  assign o_test_active = mode_sync.test_active;
  assign o_tap_reset   = ~mode_sync.test_active;

endmodule // bstap_top

// ==== bench/bstap_monitor.sv ====
// bstap_monitor: port-level checks of the test access port
// assumes bind into bstap_top; tck is still outside frames
`timescale 1ns/100ps
module bstap_monitor
  import bstap_pkg::*;
#(
  parameter int BSR_LEN = 8
)(
  input wire logic               i_mclk,        // core clk
  input wire logic               i_reset,       // core rst
  input wire logic               i_tck,         // test clk
  input wire logic               i_tms,         // mode
  input wire logic               i_tdi,         // data in
  input wire logic               i_trst_n,      // test rst
  input wire logic               o_tdo,         // data out
  input wire logic               o_tdo_oe,      // out enable
  input wire logic [BSR_LEN-1:0] o_bsr_data,    // preload
  input wire logic               o_outputs_off, // hiz
  input wire logic               o_test_active, // active
  input wire logic               o_tap_reset    // in reset
);
  logic [2:0] hi_cnt;
  // counts tms-high rises; trst counts as a full run
  wire        hi5 = (hi_cnt == 3'h5);
  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n) hi_cnt <= 3'h5;
    else if (!i_tms) hi_cnt <= 3'h0;
    else if (!hi5) hi_cnt <= hi_cnt + 3'h1;
  end
  state_reset_a:
    assert property (@(posedge i_mclk) disable iff (i_reset) $rose(hi5) |-> ##[1:8] o_tap_reset)
      else $error("tap reset flag late");
  flag_pair_a:
    assert property (@(posedge i_mclk) disable iff (i_reset) o_tap_reset != o_test_active)
      else $error("reset and active flags agree");
  hiz_clear_a:
    assert property (@(posedge i_mclk) disable iff (i_reset) $rose(o_tap_reset) |-> ##[0:8] !o_outputs_off)
      else $error("outputs stay off after reset");
  leave_cause_a:
    assert property (@(posedge i_mclk) disable iff (i_reset) $fell(o_tap_reset) |-> !hi5)
      else $error("reset left without tms low");
  oe_enter_a:
    assert property (@(posedge i_tck) disable iff (!i_trst_n) $rose(o_tdo_oe) |-> !$past(i_tms))
      else $error("tdo driven outside shift");
  oe_quiet_a:
    assert property (@(posedge i_tck) disable iff (!i_trst_n) hi_cnt >= 3'h2 |-> !o_tdo_oe)
      else $error("tdo driven after tms high");
  bypass_flow_a:
    assert property (@(posedge i_tck) disable iff (!i_trst_n)
      o_outputs_off && o_tdo_oe && $past(o_tdo_oe) |-> o_tdo == $past(i_tdi)) else $error("bypass path wrong");
  bsr_update_a:
    assert property (@(posedge i_mclk) disable iff (i_reset) $changed(o_bsr_data) |-> o_test_active && !o_outputs_off)
      else $error("preload changed out of test");
  cover property (@(posedge i_tck) o_outputs_off && o_tdo_oe);
  cover property (@(posedge i_mclk) $rose(o_tap_reset));
  cover property (@(posedge i_mclk) $changed(o_bsr_data));
endmodule // bstap_monitor

bind bstap_top bstap_monitor #(.BSR_LEN(BSR_LEN)) mon_u (.i_mclk(i_mclk), .i_reset(i_reset), .i_tck(i_tck),
  .i_tms(i_tms), .i_tdi(i_tdi), .i_trst_n(i_trst_n), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_bsr_data(o_bsr_data),
  .o_outputs_off(o_outputs_off), .o_test_active(o_test_active), .o_tap_reset(o_tap_reset));

// ==== bench/bstap_tester.sv ====
// bstap_tester: behavioural scan controller at the test port
// assumes tdo is pulled up when not driven
`timescale 1ns/100ps
module bstap_tester
(
  input  wire logic i_tdo,    // device tdo
  input  wire logic i_tdo_oe, // device drives tdo
  output logic      o_tck,    // test clock, 80 ns
  output logic      o_tms,    // mode select
  output logic      o_tdi,    // data in
  output logic      o_trst_n  // test reset
);
  wire line = i_tdo_oe ? i_tdo : 1'b1;
  initial
  begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    o_trst_n = 1'b0;
  end
  // one fall under trst so the ident code reloads
  task automatic release_trst();
    o_tck = 1'b1;
    #40;
    o_tck = 1'b0;
    #40;
    o_trst_n = 1'b1;
  endtask
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #40;
    tdo = line;
    o_tck = 1'b1;
    #40;
    o_tck = 1'b0;
  endtask
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b0, b);
    if (ir) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
endmodule // bstap_tester

// ==== bench/bstap_top_bench.sv ====
// bstap_top_bench: scan sequences against the test access port
// assumes the tester model owns tck, tms, tdi and trst
`timescale 1ns/100ps
module bstap_top_bench
  import bstap_pkg::*;
;
  localparam logic [3:0]  VER    = 4'h6;    // arbitrary value
  localparam logic [15:0] PART   = 16'h5a5c; // arbitrary value
  localparam logic [10:0] MFR    = 11'h2a7; // arbitrary value
  localparam logic [31:0] ID_EXP = {VER, PART, MFR, 1'b1};
  logic        i_mclk, i_reset, tck, tms, tdi, trst_n, tdo, tdo_oe, off, act, rst, b;
  logic [7:0]  pins, bsr;
  logic [31:0] got;
  int          error_cnt, checks_done;
  initial i_mclk = 1'b0;
  always #25 i_mclk = ~i_mclk;
  bstap_top #(.BSR_LEN(8), .ID_VER(VER), .ID_PART(PART), .ID_MFR(MFR)) dut_u (.i_mclk(i_mclk),
    .i_reset(i_reset), .i_ce(1'b1), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo),
    .o_tdo_oe(tdo_oe), .i_pin_in(pins), .i_core_out(~pins), .o_bsr_data(bsr), .o_outputs_off(off),
    .o_test_active(act), .o_tap_reset(rst));
  bstap_tester tu (.i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic load_ir(input logic [3:0] code);
    tu.scan(1'b1, 4, {28'h0, code}, got);
    chk(got, 32'h1);
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    i_reset = 1'b1;
    pins = 8'hc5;
    error_cnt = 0;
    checks_done = 0;
    repeat (5) @(negedge i_mclk);
    i_reset = 1'b0;
    #7;
    tu.release_trst();
    tu.step(1'b0, 1'b0, b);
    tu.scan(1'b0, 32, 32'h0, got);
    chk(got, ID_EXP);
    load_ir(INS_SAMPLE);
    tu.scan(1'b0, 8, 32'h3c, got);
    chk(got, {24'h0, pins});
    repeat (10) @(negedge i_mclk);
    chk({24'h0, bsr}, 32'h3c);
    load_ir(INS_BYPASS);
    tu.scan(1'b0, 8, 32'h96, got);
    chk(got, 32'h2c);
    chk({31'h0, off}, 32'h0);
    load_ir(INS_IDENT);
    tu.scan(1'b0, 32, 32'hffffffff, got);
    chk(got, ID_EXP);
    load_ir(INS_HIZ);
    repeat (10) @(negedge i_mclk);
    chk({31'h0, off}, 32'h1);
    tu.scan(1'b0, 8, 32'h5b, got);
    chk(got, 32'hb6);
    tu.step(1'b1, 1'b0, b);
    tu.step(1'b0, 1'b0, b);
    tu.step(1'b0, 1'b0, b);
    repeat (5) tu.step(1'b1, 1'b0, b);
    repeat (10) @(negedge i_mclk);
    chk({29'h0, rst, act, off}, 32'h4);
    results();
  end
  initial
  begin
    #100000;
    error_cnt++;
    results();
  end
endmodule // bstap_top_bench
